// [core/tlic_consts.vh]
// constants of the two-level interrupt controller
`ifndef TLIC_CONSTS_VH
`define TLIC_CONSTS_VH
`define TLIC_NUM_SRC      18
`define TLIC_IDX_W        5
`define TLIC_VEC_W        16
`define TLIC_VEC_BASE     16'h0003
`define TLIC_VEC_STEP_LSB 3
`define TLIC_AUTO_CLR     18'h1000F
`define TLIC_GLOBAL_BIT   7
`define TLIC_PRI_BITS     7
`define TLIC_EXT1_LSB     7
`define TLIC_EXT2_LSB     15
`define TLIC_EXT2_BITS    3
`define TLIC_SEL_PRI      0
`define TLIC_SEL_EXT1     1
`define TLIC_SEL_EXT2     2
`define TLIC_REG_RESET    8'h00
`endif

// [core/tlic_arb.v]
// per-clock priority decode of enabled pending sources
`timescale 1ns/1ps
`include "tlic_consts.vh"
module tlic_arb #(
  parameter N  = `TLIC_NUM_SRC,
  parameter IW = `TLIC_IDX_W
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          arst_n_i,
  // candidates
  input  wire [N-1:0]  req_i,
  input  wire [N-1:0]  hi_i,
  // registered decode
  output reg           valid_o,
  output reg           hi_o,
  output reg  [IW-1:0] idx_o
);
  // ==========================================================
  // fixed order: lowest index wins
  function [IW:0] first_set;
    input [N-1:0] v;
    integer k;
    begin
      first_set = {1'b0, {IW{1'b0}}};
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = {1'b1, k[IW-1:0]};
        end
      end
    end
  endfunction

  wire [IW:0] pick_hi = first_set(req_i & hi_i);
  wire [IW:0] pick_lo = first_set(req_i & ~hi_i);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      hi_o    <= 1'b0;
      idx_o   <= {IW{1'b0}};
    end else if (pick_hi[IW]) begin
      valid_o <= 1'b1;
      hi_o    <= 1'b1;
      idx_o   <= pick_hi[IW-1:0];
    end else begin
      valid_o <= pick_lo[IW];
      hi_o    <= 1'b0;
      idx_o   <= pick_lo[IW-1:0];
    end
  end
endmodule

// [core/tlic_ctrl.v]
// two-level interrupt controller top
`timescale 1ns/1ps
`include "tlic_consts.vh"
module tlic_ctrl #(
  parameter N        = `TLIC_NUM_SRC,
  parameter IW       = `TLIC_IDX_W,
  parameter AUTO_CLR = `TLIC_AUTO_CLR
) (
  // clock and reset
  input  wire                   clk_i,
  input  wire                   arst_n_i,
  // peripheral events and software flag access
  input  wire [N-1:0]           src_event_i,
  input  wire [N-1:0]           flag_set_i,
  input  wire [N-1:0]           flag_clr_i,
  // enable and priority register writes
  input  wire [2:0]             en_wr_i,
  input  wire [2:0]             pri_wr_i,
  input  wire [7:0]             wdata_i,
  // core handshake
  input  wire                   instr_done_i,
  input  wire                   next_multi_i,
  input  wire                   call_ack_i,
  input  wire                   return_from_interrupt_done_i,
  // requests to the core
  output reg                    irq_req_o,
  output reg  [`TLIC_VEC_W-1:0] vector_o,
  // register read back and state
  output reg  [N-1:0]           pending_o,
  output reg  [7:0]             primary_enable_register_o,
  output reg  [7:0]             extended_enable_register_one_o,
  output reg  [7:0]             extended_enable_register_two_o,
  output reg  [7:0]             pri_primary_o,
  output reg  [7:0]             pri_ext_one_o,
  output reg  [7:0]             pri_ext_two_o,
  output reg                    in_service_hi_o,
  output reg                    in_service_lo_o
);
  // ==========================================================
  // source enable and priority vectors
  wire [N-1:0] src_en = {
    extended_enable_register_two_o[`TLIC_EXT2_BITS-1:0],
    extended_enable_register_one_o,
    primary_enable_register_o[`TLIC_PRI_BITS-1:0]};
  wire [N-1:0] src_hi = {
    pri_ext_two_o[`TLIC_EXT2_BITS-1:0],
    pri_ext_one_o,
    pri_primary_o[`TLIC_PRI_BITS-1:0]};
  wire global_irq_enable =
    primary_enable_register_o[`TLIC_GLOBAL_BIT];
  wire [N-1:0] arb_req = pending_o & src_en
                       & {N{global_irq_enable}};

  wire          cand_valid;
  wire          cand_hi;
  wire [IW-1:0] cand_idx;

  tlic_arb #(
    .N  (N),
    .IW (IW)
  ) u_arb (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .req_i    (arb_req),
    .hi_i     (src_hi),
    .valid_o  (cand_valid),
    .hi_o     (cand_hi),
    .idx_o    (cand_idx)
  );

  // ==========================================================
  // pending flags
  reg  [IW-1:0] taken_idx;
  reg  [N-1:0]  ack_clr;
  integer       j;

  always @* begin
    ack_clr = {N{1'b0}};
    for (j = 0; j < N; j = j + 1) begin
      if (call_ack_i && irq_req_o && taken_idx == j[IW-1:0]) begin
        ack_clr[j] = AUTO_CLR[j];
      end
    end
  end

  // set beats any clear in the same cycle
  wire [N-1:0] next_pending = (pending_o & ~flag_clr_i & ~ack_clr)
                            | src_event_i
                            | flag_set_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_o <= {N{1'b0}};
    end else begin
      pending_o <= next_pending;
    end
  end

  // ==========================================================
  // enable and priority registers
  wire en_cleared =
    (en_wr_i[`TLIC_SEL_PRI]  &
      |(primary_enable_register_o & ~wdata_i)) |
    (en_wr_i[`TLIC_SEL_EXT1] &
      |(extended_enable_register_one_o & ~wdata_i)) |
    (en_wr_i[`TLIC_SEL_EXT2] &
      |(extended_enable_register_two_o & ~wdata_i));

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      primary_enable_register_o      <= `TLIC_REG_RESET;
      extended_enable_register_one_o <= `TLIC_REG_RESET;
      extended_enable_register_two_o <= `TLIC_REG_RESET;
      pri_primary_o                  <= `TLIC_REG_RESET;
      pri_ext_one_o                  <= `TLIC_REG_RESET;
      pri_ext_two_o                  <= `TLIC_REG_RESET;
    end else begin
      if (en_wr_i[`TLIC_SEL_PRI]) begin
        primary_enable_register_o <= wdata_i;
      end
      if (en_wr_i[`TLIC_SEL_EXT1]) begin
        extended_enable_register_one_o <= wdata_i;
      end
      if (en_wr_i[`TLIC_SEL_EXT2]) begin
        extended_enable_register_two_o <= wdata_i;
      end
      if (pri_wr_i[`TLIC_SEL_PRI]) begin
        pri_primary_o <= wdata_i;
      end
      if (pri_wr_i[`TLIC_SEL_EXT1]) begin
        pri_ext_one_o <= wdata_i;
      end
      if (pri_wr_i[`TLIC_SEL_EXT2]) begin
        pri_ext_two_o <= wdata_i;
      end
    end
  end

  // ==========================================================
  // instruction boundary bookkeeping
  reg clr_in_instr;
  reg hold_off;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_in_instr <= 1'b0;
      hold_off     <= 1'b0;
    end else begin
      if (instr_done_i) begin
        clr_in_instr <= en_cleared;
      end else if (en_cleared) begin
        clr_in_instr <= 1'b1;
      end
      // one more instruction runs after a return
      if (return_from_interrupt_done_i) begin
        hold_off <= 1'b1;
      end else if (instr_done_i) begin
        hold_off <= 1'b0;
      end
    end
  end

  // the decode still reflects enables from before the clear, so a
  // short follower may take it; a long follower sees the new enables
  wire stale_block = clr_in_instr & next_multi_i;
  wire level_ok = !in_service_hi_o
                & (!in_service_lo_o | cand_hi);
  wire take = instr_done_i & cand_valid & level_ok
            & !hold_off & !irq_req_o & !return_from_interrupt_done_i
            & !stale_block;

  // ==========================================================
  // request, vector and in-service state
  reg taken_hi;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_req_o       <= 1'b0;
      vector_o        <= {`TLIC_VEC_W{1'b0}};
      taken_idx       <= {IW{1'b0}};
      taken_hi        <= 1'b0;
      in_service_hi_o <= 1'b0;
      in_service_lo_o <= 1'b0;
    end else begin
      if (take) begin
        irq_req_o <= 1'b1;
        taken_idx <= cand_idx;
        taken_hi  <= cand_hi;
        vector_o  <= `TLIC_VEC_BASE + ({{(`TLIC_VEC_W-IW){1'b0}},
                     cand_idx} << `TLIC_VEC_STEP_LSB);
      end else if (call_ack_i && irq_req_o) begin
        irq_req_o <= 1'b0;
      end
      if (call_ack_i && irq_req_o) begin
        if (taken_hi) begin
          in_service_hi_o <= 1'b1;
        end else begin
          in_service_lo_o <= 1'b1;
        end
      end else if (return_from_interrupt_done_i) begin
        if (in_service_hi_o) begin
          in_service_hi_o <= 1'b0;
        end else begin
          in_service_lo_o <= 1'b0;
        end
      end
    end
  end
endmodule

// [tb/tlic_ctrl_monitor.sv]
// assertions on request, vector and flag timing
`timescale 1ns/1ps
module tlic_ctrl_monitor #(
  parameter N = 18
) (
  // clock and reset
  input wire         clk_i,
  input wire         arst_n_i,
  // design inputs
  input wire [N-1:0] src_event_i,
  input wire [N-1:0] flag_set_i,
  input wire         instr_done_i,
  input wire         call_ack_i,
  input wire         return_from_interrupt_done_i,
  // design outputs
  input wire         irq_req_o,
  input wire [15:0]  vector_o,
  input wire [N-1:0] pending_o,
  input wire [7:0]   primary_enable_register_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  chk_req_hold: assert property (irq_req_o && !call_ack_i
    |=> irq_req_o) else $error("req dropped");
  chk_vec_hold: assert property (irq_req_o && !call_ack_i
    |=> $stable(vector_o)) else $error("vector moved");
  chk_req_drop: assert property (irq_req_o && call_ack_i
    |=> !irq_req_o) else $error("req kept");
  chk_flag_set: assert property (|(src_event_i | flag_set_i)
    |=> &(pending_o | ~$past(src_event_i | flag_set_i))) else $error("no flag");
  chk_global_off: assert property (!primary_enable_register_o[7]
    && !$past(primary_enable_register_o[7]) && !irq_req_o |=> !irq_req_o)
    else $error("req while off");
  chk_take_done: assert property ($rose(irq_req_o)
    |-> $past(instr_done_i)) else $error("take mid instruction");
  chk_return_from_interrupt_wait: assert property (return_from_interrupt_done_i && !irq_req_o
    |=> !irq_req_o [*2]) else $error("take too soon");
  chk_vec_form: assert property (irq_req_o
    |-> vector_o[2:0] == 3'h3 && vector_o < 16'h0093) else $error("bad vector");
endmodule
bind tlic_ctrl tlic_ctrl_monitor #(.N(N)) u_mon (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .src_event_i(src_event_i), .flag_set_i(flag_set_i),
  .instr_done_i(instr_done_i), .call_ack_i(call_ack_i),
  .return_from_interrupt_done_i(return_from_interrupt_done_i), .irq_req_o(irq_req_o), .vector_o(vector_o),
  .pending_o(pending_o),
  .primary_enable_register_o(primary_enable_register_o));

// [tb/tlic_core_model.sv]
// core model: instruction ends and vector call acks
`timescale 1ns/1ps
module tlic_core_model (
  // controller side
  input  wire clk_i,
  input  wire arst_n_i,
  input  wire irq_req_i,
  input  wire slow_i,
  output reg  instr_done_o,
  output reg  call_ack_o
);
  reg [2:0] cnt;
  wire      wait_ack = irq_req_i && !call_ack_o;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {cnt, instr_done_o, call_ack_o} <= 5'h00;
    end else begin
      instr_done_o <= ~instr_done_o;
      cnt          <= wait_ack ? cnt + 3'h1 : 3'h0;
      call_ack_o   <= wait_ack && cnt == {slow_i, 2'h3};
    end
  end
endmodule

// [tb/tb_two_level_interrupt_controller.sv]
// bench of the two-level interrupt controller
`timescale 1ns/1ps
module tb_two_level_interrupt_controller;
  localparam [14:0] SEQ = 15'h1189;
  reg         clk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg         slow = 1'b0;
  reg         multi = 1'b0;
  reg  [68:0] stim = 69'h0;
  wire        done, ack, irq, ish, isl;
  wire [15:0] vec;
  wire [17:0] pend;
  wire [7:0]  pe, p0, e1, e2, q1, q2;
  integer     mismatches = 0;
  integer     n_tests = 0;
  integer     cycles = 0;
  always #5 clk_i = ~clk_i;
  tlic_ctrl u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .src_event_i(stim[53:36]), .flag_set_i(stim[35:18]),
    .flag_clr_i(stim[17:0]), .en_wr_i(stim[67:65]), .pri_wr_i(stim[64:62]),
    .wdata_i(stim[61:54]), .instr_done_i(done), .next_multi_i(multi),
    .call_ack_i(ack), .return_from_interrupt_done_i(stim[68]), .irq_req_o(irq),
    .vector_o(vec), .pending_o(pend), .primary_enable_register_o(pe),
    .extended_enable_register_one_o(e1), .extended_enable_register_two_o(e2),
    .pri_primary_o(p0), .pri_ext_one_o(q1), .pri_ext_two_o(q2),
    .in_service_hi_o(ish), .in_service_lo_o(isl));
  tlic_core_model u_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_req_i(irq),
    .slow_i(slow), .instr_done_o(done), .call_ack_o(ack));
  task chk(input [79:0] got, input [79:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %0t %h %h", $time, got, exp);
    end
  endtask
  // stim: return_from_interrupt, enable and priority strobes, data, events, sets, clears
  task drv(input [68:0] v, input integer n);
    @(posedge clk_i);
    stim <= v;
    @(posedge clk_i);
    stim <= 69'h0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wirq(input b);
    integer k;
    for (k = 0; k < 20 && irq !== b; k = k + 1)
      drv(69'h0, 0);
    chk(irq, b);
  endtask
  // ==========
  // scenarios
  task t_off;
    chk({pend, pe, p0, irq}, 80'h0);
    drv({7'h08, 8'h7F, 18'h20, 18'h1, 18'h0}, 6);
    chk({pend, irq}, 19'h42);
    drv({7'h08, 8'h80, 54'h0}, 6);
    chk(irq, 1'b0);
  endtask
  task t_take;
    drv({7'h08, 8'hA2, 18'h0, 18'h22, 18'h0}, 0);
    wirq(1);
    chk(vec, 16'h000B);
    wirq(0);
    chk({pend[5], pend[1], isl}, 3'h5);
    drv({1'b1, 68'h0}, 0);
    chk({isl, irq}, 2'h0);
    wirq(1);
    chk(vec, 16'h002B);
    wirq(0);
    drv({1'b1, 68'h0}, 0);
    wirq(1);
    wirq(0);
    drv({1'b1, 68'h20}, 8);
    chk({irq, pend[5]}, 2'h0);
  endtask
  task t_prio;
    integer i;
    reg [4:0] s;
    slow <= 1'b1;
    drv({7'h08, 8'h90, 54'h0}, 0);
    drv({7'h12, 8'h24, 18'h0, 18'h1210, 18'h0}, 0);
    chk({e1, q1}, 16'h2424);
    for (i = 0; i < 3; i = i + 1) begin
      s = SEQ[5*i +: 5];
      wirq(1);
      chk(vec, 16'h0003 + {s, 3'h0});
      wirq(0);
      drv(69'h0, 6);
      chk({irq, ish}, {1'b0, i < 2});
      drv({1'b1, 50'h0, 18'h1 << s}, 0);
    end
  endtask
  // enable cleared one cycle after the flag sets, then short or long follower
  task t_clr(input m);
    drv({7'h24, 8'h04, 54'h0}, 0);
    chk({e2, q2}, 16'h0404);
    drv({7'h08, 8'h82, 54'h0}, 4);
    while (done !== 1'b0) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    multi <= m;
    stim <= {33'h0, 18'h2, 18'h0};
    @(posedge clk_i);
    stim <= {7'h08, 8'h00, 54'h0};
    @(posedge clk_i);
    stim <= 69'h0;
    @(posedge clk_i);
    #1;
    chk({irq, pe}, {!m, 8'h00});
    if (!m) chk(vec, 16'h000B);
    wirq(0);
    drv({1'b1, 50'h0, 18'h2}, 4);
    chk({pend[1], isl, irq}, 3'h0);
  endtask
  task conclude;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    drv(69'h0, 0);
    t_off;
    t_take;
    t_prio;
    drv(69'h0, 4);
    t_clr(1'b0);
    t_clr(1'b1);
    conclude;
  end
endmodule
